//--- emw_ctrl.sv
`timescale 1ns/1ns
`include "emw_defines.svh"
module emw_ctrl #(
   parameter int DATA_W = 32
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic pci_config_in,
   input wire logic color_sel_in,
   input wire logic [15:0] io_addr_in,
   input wire logic io_wr_in,
   input wire logic io_rd_in,
   input wire logic [7:0] io_wdata_in,
   output logic [7:0] io_rdata_out,
   output logic io_rdata_valid_out,
   output logic input_port_strobe_out,
   output logic ramdac_rd_out,
   input wire logic [7:0] input_port_data_in,
   input wire logic [1:0] sequencer_port_cfg_in,
   input wire logic cfg_bar_wr_in,
   input wire logic [1:0] cfg_bar_be_in,
   input wire logic [15:0] cfg_bar_wdata_in,
   output logic [15:0] cfg_bar_out,
   input wire logic mapped_linear_enable_alias_in,
   input wire logic banking_en_in,
   input wire logic [5:0] page_select_in,
   input wire logic one_wait_decode_in,
   input wire logic host_valid_in,
   input wire emw_pkg::emw_acc_t host_kind_in,
   input wire logic [DATA_W-1:0] host_data_in,
   input wire logic [3:0] host_be_n_in,
   input wire logic [31:0] host_addr_in,
   output logic host_data_valid_out,
   output logic [DATA_W-1:0] host_data_out,
   output emw_pkg::emw_linear_t linear_out,
   output emw_pkg::emw_mmio_t mmio_out,
   output logic legacy_mmio_hit_out,
   output logic image_xfer_hit_out,
   output logic a000_block_out,
   output logic linear_enable_out,
   output logic addr_latch_t1_out,
   output logic cursor_decode_style_out,
   output logic video_clock_oe_out,
   output logic hsync_oe_out,
   output logic vsync_oe_out,
   output logic ras_trim_out,
   output logic [1:0] window_size_sel_out,
   output logic [7:0] general_output_port_out,
   output emw_pkg::emw_hovf_t hovf_out
);

   initial begin
      if (DATA_W != 32) begin
         $error("emw_ctrl serves only a 32-bit host data path");
      end
   end

   logic rst_meta;
   logic rst_n;
   logic strap_done;
   logic [7:0] crtc_index;
   logic [7:0] mem1;
   logic [7:0] mem2;
   logic [7:0] dac;
   logic [7:0] sync;
   logic [7:0] lwc;
   logic [15:0] position;
   logic [7:0] gop;
   logic [7:0] hovf;
   logic idx_sel;
   logic data_sel;
   logic dac_sel;
   logic reg_wr;
   logic [7:0] next_rdata;
   logic [15:0] size_mask;
   logic [31:0] lin_data;

   // Release of reset is synchronised; assertion stays asynchronous
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
      port_hit = (addr == port);
   endfunction : port_hit

   function automatic logic [31:0] swap32(input logic [31:0] d, input logic [1:0] mode,
                                          input logic [3:0] be_n, input logic be_mode);
      logic [31:0] w;
      logic [31:0] r;
      w = {d[23:16], d[31:24], d[7:0], d[15:8]};
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
      swap32 = d;
      case (mode)
         `EMW_SWAP_WORD: swap32 = w;
         `EMW_SWAP_DWORD: swap32 = r;
         `EMW_SWAP_BE: begin
            if (be_mode && be_n == `EMW_BE_ALL) begin
               swap32 = r;
            end else if (be_mode && (be_n == `EMW_BE_LOWW || be_n == `EMW_BE_HIGHW)) begin
               swap32 = w;
            end
         end
         default: swap32 = d;
      endcase
   endfunction : swap32

   function automatic logic [31:0] nibble_swap(input logic [31:0] d);
      logic [31:0] n;
      n = '0;
      for (int i = 0; i < 8; i++) begin
         n[i*4 +: 4] = (i % 2 == 0) ? d[(i+1)*4 +: 4] : d[(i-1)*4 +: 4];
      end
      nibble_swap = n;
   endfunction : nibble_swap

   assign idx_sel = port_hit(io_addr_in,
                             color_sel_in ? `EMW_PORT_IDX_COLOR : `EMW_PORT_IDX_MONO);
   assign data_sel = port_hit(io_addr_in,
                              (color_sel_in ? `EMW_PORT_IDX_COLOR : `EMW_PORT_IDX_MONO) + 16'h0001);
   assign dac_sel = port_hit(io_addr_in, `EMW_PORT_DAC_WIDX);
   assign reg_wr = io_wr_in && data_sel;

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         crtc_index <= `EMW_RST_BYTE;
      end else if (io_wr_in && idx_sel) begin
         crtc_index <= io_wdata_in;
      end
   end

   // Straps are caught one cycle after release, never under the async reset
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         strap_done <= 1'b0;
      end else begin
         strap_done <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         mem1 <= `EMW_RST_BYTE;
      end else if (!strap_done) begin
         mem1 <= pci_config_in ? `EMW_RST_MEM1_PCI : `EMW_RST_MEM1_VL;
      end else if (reg_wr && crtc_index == `EMW_IDX_MEM1) begin
         mem1 <= io_wdata_in & `EMW_MASK_MEM1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         mem2 <= `EMW_RST_BYTE;
         dac <= `EMW_RST_BYTE;
         sync <= `EMW_RST_BYTE;
         lwc <= `EMW_RST_BYTE;
         gop <= `EMW_RST_BYTE;
         hovf <= `EMW_RST_BYTE;
      end else if (reg_wr) begin
         if (crtc_index == `EMW_IDX_MEM2) begin
            mem2 <= io_wdata_in & `EMW_MASK_MEM2;
         end else if (crtc_index == `EMW_IDX_DAC) begin
            dac <= io_wdata_in & `EMW_MASK_DAC;
         end else if (crtc_index == `EMW_IDX_SYNC) begin
            sync <= io_wdata_in & `EMW_MASK_SYNC;
         end else if (crtc_index == `EMW_IDX_LWC) begin
            lwc <= io_wdata_in & `EMW_MASK_LWC;
         end else if (crtc_index == `EMW_IDX_GOP) begin
            gop <= io_wdata_in;
         end else if (crtc_index == `EMW_IDX_HOVF) begin
            hovf <= io_wdata_in & `EMW_MASK_HOVF;
         end
      end
   end

   // One store for both paths; the data port write wins a byte written by both at once
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         position <= `EMW_RST_POS_VL;
      end else if (!strap_done) begin
         position <= pci_config_in ? `EMW_RST_POS_PCI : `EMW_RST_POS_VL;
      end else begin
         if (reg_wr && crtc_index == `EMW_IDX_POS_HI) begin
            position[15:8] <= io_wdata_in;
         end else if (cfg_bar_wr_in && cfg_bar_be_in[1]) begin
            position[15:8] <= cfg_bar_wdata_in[15:8];
         end
         if (reg_wr && crtc_index == `EMW_IDX_POS_LO) begin
            position[7:0] <= io_wdata_in;
         end else if (cfg_bar_wr_in && cfg_bar_be_in[0]) begin
            position[7:0] <= cfg_bar_wdata_in[7:0];
         end
      end
   end
   assign cfg_bar_out = position;

   always_comb begin
      next_rdata = `EMW_RST_BYTE;
      if (idx_sel) begin
         next_rdata = crtc_index;
      end else if (dac_sel) begin
         next_rdata = input_port_data_in;
      end else if (crtc_index == `EMW_IDX_MEM1) begin
         next_rdata = mem1;
      end else if (crtc_index == `EMW_IDX_MEM2) begin
         next_rdata = mem2;
      end else if (crtc_index == `EMW_IDX_DAC) begin
         next_rdata = dac;
      end else if (crtc_index == `EMW_IDX_SYNC) begin
         next_rdata = sync;
      end else if (crtc_index == `EMW_IDX_LWC) begin
         next_rdata = lwc;
      end else if (crtc_index == `EMW_IDX_POS_HI) begin
         next_rdata = position[15:8];
      end else if (crtc_index == `EMW_IDX_POS_LO) begin
         next_rdata = position[7:0];
      end else if (crtc_index == `EMW_IDX_GOP) begin
         next_rdata = gop;
      end else if (crtc_index == `EMW_IDX_HOVF) begin
         next_rdata = hovf;
      end
   end

   // Input port read at 3C8 steals the RAMDAC read only under both conditions
   assign input_port_strobe_out = io_rd_in && dac_sel && dac[2] &&
                                  sequencer_port_cfg_in == `EMW_SEQ_INPORT;
   assign ramdac_rd_out = io_rd_in && dac_sel && !input_port_strobe_out;

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata_out <= `EMW_RST_BYTE;
         io_rdata_valid_out <= 1'b0;
      end else begin
         io_rdata_valid_out <= io_rd_in && (idx_sel || data_sel || input_port_strobe_out);
         if (io_rd_in && (idx_sel || data_sel || input_port_strobe_out)) begin
            io_rdata_out <= next_rdata;
         end
      end
   end

   assign mmio_out.new_en = mem1[3];
   assign mmio_out.legacy_en = mem1[4];
   assign mmio_out.legacy_window_sel = mem1[5];
   assign legacy_mmio_hit_out = host_valid_in && host_addr_in[31:20] == `EMW_HIGH_ZERO &&
      (mem1[4:3] == `EMW_MMIO_LEGACY && mem1[5] ?
       host_addr_in[19:15] == `EMW_SEG_LEGACY_B8 :
       mem1[4] && host_addr_in[19:15] == `EMW_SEG_LEGACY_A8);
   assign image_xfer_hit_out = host_valid_in && host_addr_in[31:20] == `EMW_HIGH_ZERO &&
      mem1[4] && !(mem1[4:3] == `EMW_MMIO_LEGACY && mem1[5]) &&
      host_addr_in[19:15] == `EMW_SEG_LEGACY_LO;

   assign linear_enable_out = lwc[4] | mapped_linear_enable_alias_in;
   assign a000_block_out = linear_enable_out && !(banking_en_in &&
      lwc[1:0] == `EMW_SIZE_64K && position == `EMW_POS_A000);
   assign addr_latch_t1_out = one_wait_decode_in && lwc[3];
   assign window_size_sel_out = lwc[1:0];
   assign ras_trim_out = lwc[7];
   assign cursor_decode_style_out = dac[4];
   assign video_clock_oe_out = !dac[7];
   assign hsync_oe_out = !sync[1];
   assign vsync_oe_out = !sync[2];
   assign general_output_port_out = gop;
   assign hovf_out = hovf[6:0];

   always_comb begin
      case (lwc[1:0])
         `EMW_SIZE_64K: size_mask = `EMW_MASK_64K;
         `EMW_SIZE_1M: size_mask = `EMW_MASK_1M;
         `EMW_SIZE_2M: size_mask = `EMW_MASK_2M;
         default: size_mask = `EMW_MASK_4M;
      endcase
   end

   // Registered decode so the memory sequencer sees a stable window offset
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         linear_out <= '0;
      end else begin
         linear_out.hit <= host_valid_in && linear_enable_out &&
            ((host_addr_in[31:16] & size_mask) == (position & size_mask));
         if (lwc[1:0] == `EMW_SIZE_64K && banking_en_in) begin
            linear_out.offset <= {page_select_in, host_addr_in[15:0]};
         end else begin
            linear_out.offset <= {host_addr_in[21:16] & ~size_mask[5:0], host_addr_in[15:0]};
         end
      end
   end

   assign lin_data = swap32(host_data_in, mem1[2:1], host_be_n_in, 1'b0);

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         host_data_out <= '0;
         host_data_valid_out <= 1'b0;
      end else begin
         host_data_valid_out <= host_valid_in;
         case (host_kind_in)
            emw_pkg::EMW_ACC_LINEAR: begin
               host_data_out <= mem1[6] ? nibble_swap(lin_data) : lin_data;
            end
            emw_pkg::EMW_ACC_OTHER: begin
               host_data_out <= swap32(host_data_in, mem2[1:0], host_be_n_in, 1'b1);
            end
            default: begin
               host_data_out <= host_data_in;
            end
         endcase
      end
   end

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n);

   lin_word_swap_a: assert property (host_valid_in && host_kind_in == emw_pkg::EMW_ACC_LINEAR &&
      mem1[6:1] == 6'h01 |=> host_data_out == {$past(host_data_in[23:16]),
      $past(host_data_in[31:24]), $past(host_data_in[7:0]), $past(host_data_in[15:8])})
      else $error("linear word swap wrong");
   nibble_swap_a: assert property (host_valid_in && host_kind_in == emw_pkg::EMW_ACC_LINEAR &&
      mem1[6:1] == 6'h20 |=> host_data_out[7:0] == {$past(host_data_in[3:0]),
      $past(host_data_in[7:4])}) else $error("nibble swap wrong");
   be_reverse_a: assert property (host_valid_in && host_kind_in == emw_pkg::EMW_ACC_OTHER &&
      mem2[1:0] == 2'h3 && host_be_n_in == 4'h0 |=> host_data_out[31:24] ==
      $past(host_data_in[7:0])) else $error("enable driven reverse wrong");
   be_pass_a: assert property (host_valid_in && host_kind_in == emw_pkg::EMW_ACC_OTHER &&
      mem2[1:0] == 2'h3 && host_be_n_in == 4'h1 |=> host_data_out == $past(host_data_in))
      else $error("enable driven pass wrong");
   legacy_b8_a: assert property (legacy_mmio_hit_out && mem1[5:3] == 3'h6 |->
      host_addr_in[19:15] == 5'h17) else $error("legacy window decode wrong");
   legacy_ign_a: assert property (legacy_mmio_hit_out && mem1[4:3] == 2'h3 |->
      host_addr_in[19:15] == 5'h15) else $error("window select not ignored");
   port_strobe_a: assert property (io_rd_in && io_addr_in == 16'h03C8 && dac[2] &&
      sequencer_port_cfg_in == 2'h1 |-> input_port_strobe_out && !ramdac_rd_out
      ##1 io_rdata_out == $past(input_port_data_in)) else $error("input strobe wrong");
   video_clock_out_hiz_a: assert property (reg_wr && crtc_index == 8'h55 |=>
      video_clock_oe_out == !$past(io_wdata_in[7])) else $error("video clock enable wrong");
   sync_hiz_a: assert property (reg_wr && crtc_index == 8'h56 |=>
      hsync_oe_out == !$past(io_wdata_in[1]) && vsync_oe_out == !$past(io_wdata_in[2]))
      else $error("sync enable wrong");
   lin_enable_a: assert property (mapped_linear_enable_alias_in |-> linear_enable_out &&
      (a000_block_out || banking_en_in)) else $error("linear enable wrong");
   pos_share_a: assert property (strap_done && cfg_bar_wr_in && cfg_bar_be_in[1] &&
      !reg_wr |=> cfg_bar_out[15:8] == $past(cfg_bar_wdata_in[15:8]))
      else $error("shared position wrong");
   reserved_zero_a: assert property (reg_wr && crtc_index == 8'h54 |=>
      mem2[7:2] == 6'h00) else $error("reserved bits kept");
   hovf_map_a: assert property (reg_wr && crtc_index == 8'h5D |=>
      hovf_out.h_blank_end_hi == $past(io_wdata_in[3])) else $error("overflow map wrong");

   lin_hit_c: cover property (linear_out.hit && lwc[1:0] == 2'h3);
   strobe_c: cover property (input_port_strobe_out);
   be_word_c: cover property (host_valid_in && mem2[1:0] == 2'h3 && host_be_n_in == 4'hC);
   legacy_c: cover property (legacy_mmio_hit_out && mem1[5]);

endmodule : emw_ctrl

//--- emw_defines.svh
// Notes on behaviour
// - Linear accesses swap per field: 00 none, 01 word, 10 dword, 11 reserved.
// - Mapped I/O select: 00 off, 01 new, 10 legacy, 11 both.
// - Legacy window A8000-AFFFF leaving A0000-A7FFF for images, or B8000-BFFFF.
// - Legacy window select only matters while mapped I/O select is 10.
// - Nibble swap bit exchanges nibbles of every byte on linear accesses.
// - Other accesses use second swap field; 11 means byte-enable driven swap.
// - Enables 0000 reverse dword, 0011 or 1100 swap word, others pass.
// - Read of 3C8 with enable and sequencer 01 strobes input port, else RAMDAC.
// - Cursor decode style bit picks one of two cursor array interpretations.
// - Video clock tri-state bit releases the video clock output.
// - Separate bits release the horizontal and vertical sync outputs.
// - Window size field: 64K, 1M, 2M or 4M.
// - Latch delay: 0 latch in T2, 1 in T1, only with one decode wait.
// - Linear enable is OR of register bit and mapped control alias.
// - Linear enable blocks A0000 region unless banked 64K window at A000.
// - RAS trim moves half a clock from precharge to RAS low time.
// - Position gives address bits 31-16, low bits ignored per window size.
// - Position shares storage with PCI base address 0 bits 31-16.
// - Position resets to 000A on local bus, 7000 on PCI.
// - Banked 64K window uses six-bit page field as display page.
// - Overflow register gives bit 8 or bit 6 of horizontal timing values.
// - Registers reached by writing index port then accessing data port.
`ifndef EMW_DEFINES_SVH
`define EMW_DEFINES_SVH
`define EMW_PORT_IDX_MONO 16'h03B4
`define EMW_PORT_IDX_COLOR 16'h03D4
`define EMW_PORT_DAC_WIDX 16'h03C8
`define EMW_IDX_MEM1 8'h53
`define EMW_IDX_MEM2 8'h54
`define EMW_IDX_DAC 8'h55
`define EMW_IDX_SYNC 8'h56
`define EMW_IDX_LWC 8'h58
`define EMW_IDX_POS_HI 8'h59
`define EMW_IDX_POS_LO 8'h5A
`define EMW_IDX_GOP 8'h5C
`define EMW_IDX_HOVF 8'h5D
`define EMW_MASK_MEM1 8'h7E
`define EMW_MASK_MEM2 8'h03
`define EMW_MASK_DAC 8'h94
`define EMW_MASK_SYNC 8'h06
`define EMW_MASK_LWC 8'h9B
`define EMW_MASK_HOVF 8'h7F
`define EMW_RST_BYTE 8'h00
`define EMW_RST_MEM1_VL 8'h00
`define EMW_RST_MEM1_PCI 8'h08
`define EMW_RST_POS_VL 16'h000A
`define EMW_RST_POS_PCI 16'h7000
`define EMW_POS_A000 16'h000A
`define EMW_SWAP_NONE 2'h0
`define EMW_SWAP_WORD 2'h1
`define EMW_SWAP_DWORD 2'h2
`define EMW_SWAP_BE 2'h3
`define EMW_BE_ALL 4'h0
`define EMW_BE_LOWW 4'h3
`define EMW_BE_HIGHW 4'hC
`define EMW_MMIO_NEW 2'h1
`define EMW_MMIO_LEGACY 2'h2
`define EMW_MMIO_BOTH 2'h3
`define EMW_SEQ_INPORT 2'h1
`define EMW_SIZE_64K 2'h0
`define EMW_SIZE_1M 2'h1
`define EMW_SIZE_2M 2'h2
`define EMW_MASK_64K 16'hFFFF
`define EMW_MASK_1M 16'hFFF0
`define EMW_MASK_2M 16'hFFE0
`define EMW_MASK_4M 16'hFFC0
`define EMW_SEG_LEGACY_LO 5'h14
`define EMW_SEG_LEGACY_A8 5'h15
`define EMW_SEG_LEGACY_B8 5'h17
`define EMW_SEG_A000 4'hA
`define EMW_HIGH_ZERO 12'h000
`endif

//--- emw_pkg.sv
package emw_pkg;
   typedef enum logic [2:0] {
      EMW_ACC_LINEAR = 3'h1,
      EMW_ACC_IMAGE = 3'h2,
      EMW_ACC_OTHER = 3'h4
   } emw_acc_t;

   typedef struct packed {
      logic fifo_fetch_start_hi;
      logic h_sync_end_hi;
      logic h_sync_start_hi;
      logic h_blank_end_hi;
      logic h_blank_start_hi;
      logic h_display_end_hi;
      logic h_total_hi;
   } emw_hovf_t;

   typedef struct packed {
      logic new_en;
      logic legacy_en;
      logic legacy_window_sel;
   } emw_mmio_t;

   typedef struct packed {
      logic hit;
      logic [21:0] offset;
   } emw_linear_t;
endpackage : emw_pkg

//--- emw_host.sv
`timescale 1ns/1ns
module emw_host (
   input wire logic clk_in,
   input wire logic color_in,
   output logic [15:0] addr_out,
   output logic wr_out,
   output logic rd_out,
   output logic [7:0] wdata_out
);
   initial begin
      addr_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
   end
   // Idle bus shows the inverse of the last cycle so stale values never pass
   task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      wr_out = w;
      rd_out = !w;
      wdata_out = d;
      @(negedge clk_in);
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask : cyc
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      cyc(color_in ? 16'h03D4 : 16'h03B4, 1'b1, i);
      cyc(color_in ? 16'h03D5 : 16'h03B5, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [7:0] i);
      cyc(color_in ? 16'h03D4 : 16'h03B4, 1'b1, i);
      cyc(color_in ? 16'h03D5 : 16'h03B5, 1'b0, ~i);
   endtask : rd
endmodule : emw_host

//--- emw_ctrl_test.sv
`timescale 1ns/1ns
module emw_ctrl_test;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic pci_config_in = 1'b1;
   logic color_sel_in = 1'b1;
   logic [15:0] io_addr_in;
   logic io_wr_in, io_rd_in, io_rdata_valid_out, input_port_strobe_out, ramdac_rd_out;
   logic [7:0] io_wdata_in, io_rdata_out, general_output_port_out;
   logic [7:0] input_port_data_in = 8'h00;
   logic [1:0] sequencer_port_cfg_in = 2'h0;
   logic cfg_bar_wr_in = 1'b0;
   logic [1:0] cfg_bar_be_in = 2'h3;
   logic [15:0] cfg_bar_wdata_in = 16'h0000;
   logic [15:0] cfg_bar_out;
   logic mapped_linear_enable_alias_in = 1'b0;
   logic banking_en_in = 1'b0;
   logic [5:0] page_select_in = 6'h00;
   logic one_wait_decode_in = 1'b1;
   logic host_valid_in = 1'b0;
   emw_pkg::emw_acc_t host_kind_in = emw_pkg::EMW_ACC_IMAGE;
   logic [31:0] host_data_in = 32'h0000_0000;
   logic [31:0] host_addr_in = 32'h0000_0000;
   logic [3:0] host_be_n_in = 4'hF;
   logic host_data_valid_out, legacy_mmio_hit_out, image_xfer_hit_out, a000_block_out;
   logic linear_enable_out, addr_latch_t1_out, cursor_decode_style_out, video_clock_oe_out;
   logic hsync_oe_out, vsync_oe_out, ras_trim_out;
   logic [1:0] window_size_sel_out, m;
   logic [31:0] host_data_out, r, e, a, lim;
   emw_pkg::emw_linear_t linear_out;
   emw_pkg::emw_mmio_t mmio_out;
   emw_pkg::emw_hovf_t hovf_out;
   int bad_count = 0;
   int n_tests = 0;
   logic [56:0] q_h[$];
   logic [56:0] e_h;
   logic [7:0] q_r[$];
   logic [7:0] d;
   logic b8;
   logic [7:0] ix [8] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h5C, 8'h5D};
   logic [7:0] mk [8] = '{8'h7E, 8'h03, 8'h94, 8'h06, 8'h00, 8'h9B, 8'hFF, 8'h7F};
   logic [3:0] bt [4] = '{4'h0, 4'h3, 4'hC, 4'h1};

   always #5 mclk_in = ~mclk_in;

   emw_host host (.clk_in(mclk_in), .color_in(color_sel_in), .addr_out(io_addr_in),
      .wr_out(io_wr_in), .rd_out(io_rd_in), .wdata_out(io_wdata_in));

   emw_ctrl dut (.mclk_in, .reset_n_in, .pci_config_in, .color_sel_in, .io_addr_in,
      .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out, .io_rdata_valid_out,
      .input_port_strobe_out, .ramdac_rd_out, .input_port_data_in, .sequencer_port_cfg_in,
      .cfg_bar_wr_in, .cfg_bar_be_in, .cfg_bar_wdata_in, .cfg_bar_out,
      .mapped_linear_enable_alias_in, .banking_en_in, .page_select_in, .one_wait_decode_in,
      .host_valid_in, .host_kind_in, .host_data_in, .host_be_n_in, .host_addr_in,
      .host_data_valid_out, .host_data_out, .linear_out, .mmio_out, .legacy_mmio_hit_out,
      .image_xfer_hit_out, .a000_block_out, .linear_enable_out, .addr_latch_t1_out,
      .cursor_decode_style_out, .video_clock_oe_out, .hsync_oe_out, .vsync_oe_out,
      .ras_trim_out, .window_size_sel_out, .general_output_port_out, .hovf_out);

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", n, x, g);
      end
   endtask : chk

   task automatic end_of_test();
      $display("tests %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   task automatic rr(input logic [7:0] i, input logic [7:0] x);
      q_r.push_back(x);
      host.rd(i);
   endtask : rr

   task automatic rst(input logic p);
      @(negedge mclk_in);
      reset_n_in = 1'b0;
      pci_config_in = p;
      repeat (4) @(negedge mclk_in);
      reset_n_in = 1'b1;
      repeat (6) @(negedge mclk_in);
   endtask : rst

   function automatic logic [31:0] sw(input logic [1:0] s, input logic [31:0] x);
      case (s)
         2'h1: return {x[23:16], x[31:24], x[7:0], x[15:8]};
         2'h2: return {x[7:0], x[15:8], x[23:16], x[31:24]};
         default: return x;
      endcase
   endfunction : sw

   // Note l is {check hit, check offset, hit, offset}; h is {legacy hit, image hit}
   task automatic ha(input emw_pkg::emw_acc_t k, input logic [31:0] ad, input logic [24:0] l,
      input logic [31:0] x, input logic [1:0] h);
      @(negedge mclk_in);
      host_valid_in = 1'b1;
      host_kind_in = k;
      host_addr_in = ad;
      host_data_in = r;
      q_h.push_back({l, x});
      #1;
      chk("legacy_hit", h[1], legacy_mmio_hit_out);
      chk("image_hit", h[0], image_xfer_hit_out);
      @(negedge mclk_in);
      host_valid_in = 1'b0;
      host_addr_in = ~ad;
      host_data_in = ~r;
   endtask : ha

   task automatic dac(input logic [1:0] s, input logic t);
      sequencer_port_cfg_in = s;
      fork
         host.cyc(16'h03C8, 1'b0, 8'h00);
         begin
            @(negedge mclk_in);
            #1;
            chk("gp_strobe", t, input_port_strobe_out);
            chk("ramdac_rd", !t, ramdac_rd_out);
         end
      join
   endtask : dac

   always @(negedge mclk_in) begin
      if (io_rdata_valid_out === 1'b1 && q_r.size() > 0) chk("rdata", q_r.pop_front(), io_rdata_out);
      if (host_data_valid_out === 1'b1 && q_h.size() > 0) begin
         e_h = q_h.pop_front();
         chk("hdata", e_h[31:0], host_data_out);
         if (e_h[56]) chk("lin_hit", e_h[54], linear_out.hit);
         if (e_h[55]) chk("lin_off", e_h[53:32], linear_out.offset);
      end
   end

   initial begin
      #500_000;
      bad_count++;
      end_of_test();
   end

   initial begin
      void'($urandom(25928));
      rst(1'b1);
      chk("bar", 16'h7000, cfg_bar_out);
      rr(8'h59, 8'h70);
      rr(8'h5A, 8'h00);
      for (int i = 0; i < 8; i++) begin
         rr(ix[i], i == 0 ? 8'h08 : 8'h00);
         host.wr(ix[i], 8'hFF);
         rr(ix[i], mk[i]);
         host.wr(ix[i], 8'h00);
      end
      repeat (4) begin
         d = 8'($urandom);
         host.wr(8'h55, d);
         host.wr(8'h56, d);
         host.wr(8'h5D, d);
         host.wr(8'h58, d & 8'h8B);
         host.wr(8'h5C, d);
         chk("cursor", d[4], cursor_decode_style_out);
         chk("video_clock_out_oe", !d[7], video_clock_oe_out);
         chk("hsync_oe", !d[1], hsync_oe_out);
         chk("vsync_oe", !d[2], vsync_oe_out);
         chk("hovf", d[6:0], hovf_out);
         chk("size", d[1:0], window_size_sel_out);
         chk("ras", d[7], ras_trim_out);
         chk("latch", d[3], addr_latch_t1_out);
         chk("gp_out", d, general_output_port_out);
         rr(8'h5C, d);
      end
      host.wr(8'h59, 8'h00);
      host.wr(8'h5A, 8'h0A);
      for (int i = 0; i < 8; i++) begin
         mapped_linear_enable_alias_in = i[1];
         banking_en_in = i[2];
         host.wr(8'h58, {3'h0, i[0], 4'h0});
         chk("lin_en", i[0] | i[1], linear_enable_out);
         chk("a000", (i[0] | i[1]) & !i[2], a000_block_out);
      end
      host.wr(8'h58, 8'h11);
      chk("a000", 1'b1, a000_block_out);
      @(negedge mclk_in);
      cfg_bar_wr_in = 1'b1;
      cfg_bar_be_in = 2'h2;
      cfg_bar_wdata_in = 16'h1299;
      @(negedge mclk_in);
      cfg_bar_wr_in = 1'b0;
      chk("bar", 16'h120A, cfg_bar_out);
      rr(8'h59, 8'h12);
      host.wr(8'h5A, 8'h34);
      chk("bar", 16'h1234, cfg_bar_out);
      mapped_linear_enable_alias_in = 1'b0;
      banking_en_in = 1'b0;
      for (int s = 1; s < 4; s++) begin
         host.wr(8'h58, {6'h04, s[1:0]});
         lim = (32'h0010_0000 << (s - 1)) - 1;
         a = (32'h1234_0000 & ~lim) | ($urandom & lim);
         r = $urandom;
         ha(emw_pkg::EMW_ACC_LINEAR, a, {3'b111, 22'(a & lim)}, r, 2'b00);
         ha(emw_pkg::EMW_ACC_LINEAR, a + lim + 1, 25'h100_0000, r, 2'b00);
      end
      host.wr(8'h58, 8'h10);
      banking_en_in = 1'b1;
      page_select_in = 6'($urandom);
      a = 32'h1234_0000 | 16'($urandom);
      ha(emw_pkg::EMW_ACC_LINEAR, a, {3'b111, page_select_in, a[15:0]}, r, 2'b00);
      banking_en_in = 1'b0;
      host.wr(8'h58, 8'h00);
      host.wr(8'h54, 8'h02);
      for (int i = 0; i < 8; i++) begin
         host.wr(8'h53, {2'h0, i[2], i[1:0], 3'h0});
         chk("mmio_new", i[0], mmio_out.new_en);
         chk("mmio_leg", i[1], mmio_out.legacy_en);
         chk("legacy_window_sel", i[2], mmio_out.legacy_window_sel);
         b8 = (i[1:0] == 2'h2) & i[2];
         r = $urandom;
         ha(emw_pkg::EMW_ACC_IMAGE, 32'h000A_8000, 25'h0, r, {i[1] & !b8, 1'b0});
         ha(emw_pkg::EMW_ACC_IMAGE, 32'h000B_8000, 25'h0, r, {b8, 1'b0});
         ha(emw_pkg::EMW_ACC_IMAGE, 32'h000A_0000, 25'h0, r, {1'b0, i[1] & !b8});
      end
      for (int i = 0; i < 8; i++) begin
         host.wr(8'h53, {1'b0, i[2], 3'h0, i[1:0], 1'b0});
         r = $urandom;
         e = sw(i[1:0], r);
         if (i[2]) e = ((e & 32'hF0F0_F0F0) >> 4) | ((e & 32'h0F0F_0F0F) << 4);
         ha(emw_pkg::EMW_ACC_LINEAR, 32'h0000_0000, 25'h0, e, 2'b00);
      end
      // Nibble swap stays on here to show it never leaks into other accesses
      host.wr(8'h53, 8'h40);
      for (int i = 0; i < 16; i++) begin
         host.wr(8'h54, {6'h00, i[3:2]});
         host_be_n_in = bt[i[1:0]];
         r = $urandom;
         m = i[3:2];
         if (m == 2'h3) m = i[1:0] == 0 ? 2'h2 : (i[1:0] == 3 ? 2'h0 : 2'h1);
         ha(emw_pkg::EMW_ACC_OTHER, 32'h0000_0000, 25'h0, sw(m, r), 2'b00);
      end
      color_sel_in = 1'b0;
      host.wr(8'h5C, 8'hA5);
      rr(8'h5C, 8'hA5);
      color_sel_in = 1'b1;
      host.wr(8'h55, 8'h04);
      input_port_data_in = 8'($urandom);
      q_r.push_back(input_port_data_in);
      dac(2'h1, 1'b1);
      dac(2'h2, 1'b0);
      host.wr(8'h55, 8'h00);
      dac(2'h1, 1'b0);
      rst(1'b0);
      rr(8'h59, 8'h00);
      rr(8'h5A, 8'h0A);
      rr(8'h53, 8'h00);
      for (int i = 0; i < 10 && q_r.size() + q_h.size() > 0; i++) @(negedge mclk_in);
      if (q_r.size() + q_h.size() > 0) bad_count++;
      end_of_test();
   end
endmodule : emw_ctrl_test
